// ### vlac_pkg.sv
// package: register map, field layout, reset values and timing for the
// visible-light converter configuration block.
// assumes a 20 MHz hclk and 32-bit word-aligned register slots.
package vlac_pkg;

  // ---------------------------------------------------------------
  // register indices and byte address width
  // ---------------------------------------------------------------
  localparam logic [7:0]  VIS_RECOVERY_SELECT_IDX = 8'h10;
  localparam logic [7:0]  VIS_GAIN_EXPONENT_IDX   = 8'h11;
  localparam logic [7:0]  HIGH_SIGNAL_RANGE_SELECT_CONTROL_IDX   = 8'h12;
  localparam logic [7:0]  MEAS_CONTROL_IDX        = 8'h13;
  localparam logic [7:0]  MEAS_STATUS_IDX         = 8'h14;
  localparam int          ADDR_W                  = 10;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          REC_LSB        = 4;
  localparam int          REC_MSB        = 6;
  localparam int          GAIN_LSB       = 0;
  localparam int          GAIN_MSB       = 2;
  localparam int          RANGE_BIT      = 5;
  localparam int          START_VIS_BIT  = 0;
  localparam int          START_IR_BIT   = 1;
  localparam int          DONE_BIT       = 4;
  localparam logic [7:0]  REC_RESET      = 8'h70;
  localparam logic [7:0]  GAIN_RESET     = 8'h00;
  localparam logic [7:0]  RANGE_RESET    = 8'h00;
  localparam logic [2:0]  IR_REC_DEFAULT = 3'h7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_KHZ        = 20000;
  localparam int          ADC_CLK_NS     = 50;
  localparam int          ADC_DIV_RAW    = ADC_CLK_NS * CLK_KHZ / 1000000;
  localparam int          ADC_DIV        = (ADC_DIV_RAW < 1) ? 1
                                                             : ADC_DIV_RAW;
  localparam int          REC_CNT_W      = 17;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    VLAC_IDLE      = 2'b00,
    VLAC_RECOVER   = 2'b01,
    VLAC_INTEGRATE = 2'b10
  } vlac_state_t;

  // recovery length in adc clocks for a three-bit code
  function automatic logic [9:0] vlac_rec_clocks(input logic [2:0] code);
    if (code == 3'h0) begin
      vlac_rec_clocks = 10'h001;
    end else begin
      // shift amount widened so codes 6 and 7 do not wrap
      vlac_rec_clocks = 10'((11'h001 << ({1'b0, code} + 4'h2)) - 11'h001);
    end
  endfunction : vlac_rec_clocks

endpackage : vlac_pkg

// ### vlac_seq_if.sv
// interface: settings and handshake between register file and sequencer.
// assumes both ends run on hclk.
`timescale 1ns/10ps
`default_nettype none
interface vlac_seq_if;
  import vlac_pkg::*;
  logic        start;
  logic        ir_meas;
  logic [2:0]  rec_code;
  logic [2:0]  gain;
  logic        high_range;
  logic        busy;
  logic        done;
  vlac_state_t state;
  modport ctrl (output start, ir_meas, rec_code, gain, high_range,
                input busy, done, state);
  modport seq  (input start, ir_meas, rec_code, gain, high_range,
                output busy, done, state);
endinterface : vlac_seq_if
`default_nettype wire

// ### vlac_seq.sv
// recovery and integration sequencer for one conversion.
// assumes settings stay stable while busy; one adc clock per ADC_DIV hclks.
`timescale 1ns/10ps
`default_nettype none
module vlac_seq
  import vlac_pkg::*;
#(
  parameter int INTEG_CLOCKS = 16
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  vlac_seq_if.seq    sif,
  output var  logic  adc_recovering,
  output var  logic  adc_sample_en,
  output var  logic  adc_high_range
);

  logic [7:0]           div_r;
  logic                 adc_tick;
  logic [REC_CNT_W-1:0] rec_cnt_r;
  logic [6:0]           gdiv_r;
  logic [7:0]           int_cnt_r;
  logic                 slow_tick;
  vlac_state_t          state_r;

  // ---------------------------------------------------------------
  // adc clock enable
  // ---------------------------------------------------------------
  assign adc_tick = (div_r == 8'(ADC_DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 8'h00;
    end else if (adc_tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // divided adc clock for integration
  assign slow_tick = adc_tick && (gdiv_r == 7'((8'h01 << sif.gain) - 8'h01));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gdiv_r <= 7'h00;
    end else if (state_r != VLAC_INTEGRATE || slow_tick) begin
      gdiv_r <= 7'h00;
    end else if (adc_tick) begin
      gdiv_r <= gdiv_r + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= VLAC_IDLE;
      rec_cnt_r <= '0;
      int_cnt_r <= 8'h00;
      sif.done  <= 1'b0;
    end else begin
      sif.done <= 1'b0;
      case (state_r)
        VLAC_IDLE: begin
          if (sif.start) begin
            state_r   <= VLAC_RECOVER;
            // recovery scaled by two to the gain
            rec_cnt_r <= REC_CNT_W'(vlac_rec_clocks(sif.rec_code))
                         << sif.gain;
          end
        end
        VLAC_RECOVER: begin
          if (adc_tick) begin
            if (rec_cnt_r == REC_CNT_W'(1)) begin
              state_r   <= VLAC_INTEGRATE;
              int_cnt_r <= 8'(INTEG_CLOCKS);
            end
            rec_cnt_r <= rec_cnt_r - REC_CNT_W'(1);
          end
        end
        VLAC_INTEGRATE: begin
          if (slow_tick) begin
            if (int_cnt_r == 8'h01) begin
              state_r  <= VLAC_IDLE;
              sif.done <= 1'b1;
            end
            int_cnt_r <= int_cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= VLAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_high_range <= 1'b0;
    end else if (sif.start && state_r == VLAC_IDLE) begin
      adc_high_range <= sif.high_range;
    end
  end

  assign sif.busy       = (state_r != VLAC_IDLE);
  assign sif.state      = state_r;
  assign adc_recovering = (state_r == VLAC_RECOVER);
  assign adc_sample_en  = (state_r == VLAC_INTEGRATE) && slow_tick;

endmodule : vlac_seq
`default_nettype wire

// ### vlac_top.sv
// visible-light converter configuration: ahb-lite register slave plus
// recovery / integration sequencer.
// assumes a single ahb-lite master, whole-word single transfers, hclk 20 MHz.
//
// Operation
// - each visible conversion first waits 1, 7, 15, 31, 63, 127, 255 or 511 adc clocks per the recovery code in bits 6:4.
// - one adc clock lasts 50 ns and the recovery length is multiplied by two to the gain exponent.
// - integration is stretched by two to the gain exponent in bits 2:0 by dividing the adc clock.
// - gain exponent codes up to 7 are accepted, giving a factor of 128.
// - bit 5 of the range register selects normal range at 0 or the high range with gain over 14.5 at 1.
// - on early revisions the recovery and range settings also govern infrared conversions.
`timescale 1ns/10ps
`default_nettype none
module vlac_top
  import vlac_pkg::*;
#(
  parameter bit EARLY_REVISION = 1'b0,
  parameter int INTEG_CLOCKS   = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  output var  logic        adc_recovering,
  output var  logic        adc_sample_en,
  output var  logic        adc_high_range,
  output var  logic        adc_infrared_sel
);

  vlac_seq_if sif ();

  logic [2:0]        rec_r;
  logic [2:0]        gain_r;
  logic              range_r;
  logic              done_r;
  logic              ir_r;
  logic              wr_pend_r;
  logic              rd_pend_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0]       hrdata_r;
  logic              addr_ok;
  logic              start_vis;
  logic              start_ir;
  logic              ctrl_wr;
  logic              done_clr;

  // ---------------------------------------------------------------
  // ahb-lite address and data phase
  // ---------------------------------------------------------------
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        idx);
    is_reg = (a == ADDR_W'({idx, 2'b00}));
  endfunction : is_reg

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
    end else if (rd_pend_r) begin
      rd_pend_r <= 1'b0;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_r <= haddr[ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state so read data comes from a flip-flop
  assign hreadyout = !rd_pend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_r   <= REC_RESET[REC_MSB:REC_LSB];
      gain_r  <= GAIN_RESET[GAIN_MSB:GAIN_LSB];
      range_r <= RANGE_RESET[RANGE_BIT];
    end else if (wr_pend_r) begin
      // only the defined fields are stored
      if (is_reg(addr_r, VIS_RECOVERY_SELECT_IDX)) begin
        rec_r <= hwdata[REC_MSB:REC_LSB];
      end
      if (is_reg(addr_r, VIS_GAIN_EXPONENT_IDX)) begin
        gain_r <= hwdata[GAIN_MSB:GAIN_LSB];
      end
      if (is_reg(addr_r, HIGH_SIGNAL_RANGE_SELECT_CONTROL_IDX)) begin
        range_r <= hwdata[RANGE_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= 32'h0000_0000;
      if (is_reg(addr_r, VIS_RECOVERY_SELECT_IDX)) begin
        hrdata_r[REC_MSB:REC_LSB] <= rec_r;
      end
      if (is_reg(addr_r, VIS_GAIN_EXPONENT_IDX)) begin
        hrdata_r[GAIN_MSB:GAIN_LSB] <= gain_r;
      end
      if (is_reg(addr_r, HIGH_SIGNAL_RANGE_SELECT_CONTROL_IDX)) begin
        hrdata_r[RANGE_BIT] <= range_r;
      end
      if (is_reg(addr_r, MEAS_STATUS_IDX)) begin
        hrdata_r[0]        <= sif.busy;
        hrdata_r[1]        <= ir_r;
        hrdata_r[3:2]      <= sif.state;
        hrdata_r[DONE_BIT] <= done_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // measurement control and status
  // ---------------------------------------------------------------
  assign ctrl_wr   = wr_pend_r && is_reg(addr_r, MEAS_CONTROL_IDX);
  assign start_vis = ctrl_wr && hwdata[START_VIS_BIT] && !sif.busy;
  assign start_ir  = ctrl_wr && hwdata[START_IR_BIT] &&
                     !hwdata[START_VIS_BIT] && !sif.busy;
  assign done_clr  = wr_pend_r && is_reg(addr_r, MEAS_STATUS_IDX) &&
                     hwdata[DONE_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_r <= 1'b0;
    end else if (start_vis || start_ir) begin
      ir_r <= start_ir;
    end
  end

  // completion flag: a new completion wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (sif.done) begin
      done_r <= 1'b1;
    end else if (done_clr) begin
      done_r <= 1'b0;
    end
  end

  // infrared uses its own fixed recovery and range unless early silicon; its gain is always 0
  assign sif.start      = start_vis || start_ir;
  assign sif.ir_meas    = start_ir;
  assign sif.rec_code   = (start_ir && !EARLY_REVISION) ? IR_REC_DEFAULT
                                                        : rec_r;
  assign sif.gain       = ((start_ir || (sif.busy && ir_r)) && 1'b1)
                          ? 3'h0 : gain_r;
  assign sif.high_range = (start_ir && !EARLY_REVISION) ? 1'b0
                                                        : range_r;
  assign adc_infrared_sel = ir_r;

  vlac_seq #(
    .INTEG_CLOCKS (INTEG_CLOCKS)
  ) u_seq (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .sif            (sif),
    .adc_recovering (adc_recovering),
    .adc_sample_en  (adc_sample_en),
    .adc_high_range (adc_high_range)
  );

endmodule : vlac_top
`default_nettype wire

// ### vlac_chk.sv
// checker: bus handshake, reserved bits and conversion timing at the top.
// assumes one ahb-lite master with hready tied to hreadyout.
`timescale 1ns/10ps
`default_nettype none
module vlac_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        adc_recovering,
  input wire logic        adc_sample_en,
  input wire logic        adc_high_range,
  input wire logic        adc_infrared_sel
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam int REC_MAX = 65408;
  logic        acc;
  logic [16:0] rec_cnt_r;
  assign acc = hsel && hready && htrans[1];
  // length of the current recovery run so far
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_cnt_r <= 17'h0;
    end else begin
      rec_cnt_r <= adc_recovering ? rec_cnt_r + 17'h1 : 17'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  AST_RD_WAIT: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  AST_WR_NOWAIT: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_REC_RSVD: assert property (acc && !hwrite && haddr[9:0] == 10'h040
    |-> ##2 (hrdata & 32'hFFFF_FF8F) == 32'h0)
    else $error("recovery register reserved bits set");
  AST_GAIN_RSVD: assert property (acc && !hwrite && haddr[9:0] == 10'h044
    |-> ##2 (hrdata & 32'hFFFF_FFF8) == 32'h0)
    else $error("gain register reserved bits set");
  AST_RANGE_RSVD: assert property (acc && !hwrite && haddr[9:0] == 10'h048
    |-> ##2 (hrdata & 32'hFFFF_FFDF) == 32'h0)
    else $error("range register reserved bits set");
  AST_SAMPLE_NOT_REC: assert property (adc_sample_en |-> !adc_recovering)
    else $error("sampling during recovery");
  AST_RANGE_STABLE: assert property (adc_recovering && $past(adc_recovering)
    |-> $stable(adc_high_range) && $stable(adc_infrared_sel))
    else $error("range changed during recovery");
  AST_REC_MAX: assert property (adc_recovering |-> rec_cnt_r < REC_MAX)
    else $error("recovery longer than the largest setting");
  AST_FIRST_TICK: assert property ($fell(adc_recovering)
    |-> ##[0:127] adc_sample_en)
    else $error("no divided tick after recovery");
endmodule : vlac_chk
bind vlac_top vlac_chk vlac_chk_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .adc_recovering, .adc_sample_en, .adc_high_range, .adc_infrared_sel);
`default_nettype wire

// ### test_vlac_top.sv
// testbench: register access and recovery / integration timing of vlac_top.
// assumes the checker is bound to vlac_top; early revision, 2 integ clocks.
`timescale 1ns/10ps
`default_nettype none
module test_vlac_top;
  import vlac_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        adc_recovering, adc_sample_en, adc_high_range, adc_infr;
  int          n_mismatch = 0;
  int          n_tests = 0;
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  vlac_top #(.EARLY_REVISION(1'b1), .INTEG_CLOCKS(2)) vlac_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_recovering(adc_recovering), .adc_sample_en(adc_sample_en),
    .adc_high_range(adc_high_range), .adc_infrared_sel(adc_infr));
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // entered just after a rising edge; returns just after the data edge
  task automatic bus(input logic wr, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input string what, input logic [31:0] a, exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask : rd
  // one conversion: recovery length, range, tick count and spacing, status
  task automatic conv(input logic [2:0] code, gain, input logic rng, ir);
    int n, eg, pulses, last, gap;
    eg = ir ? 0 : int'(gain);
    pulses = 0;
    last = 0;
    gap = 0;
    wr(32'h40, {25'h0, code, 4'h0});
    wr(32'h44, {29'h0, gain});
    wr(32'h48, {26'h0, rng, 5'h0});
    wr(32'h4C, ir ? 32'h2 : 32'h1);
    n = 0;
    while (adc_recovering !== 1'b1 && n < 8) begin
      @(posedge hclk);
      n++;
    end
    chk("high range", {31'h0, rng}, {31'h0, adc_high_range});
    chk("infrared", {31'h0, ir}, {31'h0, adc_infr});
    n = 0;
    while (adc_recovering === 1'b1 && n < 70000) begin
      @(posedge hclk);
      n++;
    end
    chk("recovery", 32'(((code == 3'h0) ? 1 : (1 << (code + 2)) - 1) << eg),
        32'(n));
    for (int i = 1; i <= 2 * (1 << eg) + 4; i++) begin
      if (adc_sample_en === 1'b1) begin
        gap = i - last;
        last = i;
        pulses++;
      end
      @(posedge hclk);
    end
    chk("ticks", 32'h2, 32'(pulses));
    chk("tick spacing", 32'(1 << eg), 32'(gap));
    rd("status", 32'h50, {30'h4, ir, 1'b0});
    wr(32'h50, 32'h10);
    rd("status clear", 32'h50, {30'h0, ir, 1'b0});
  endtask : conv
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    rd("recovery reset", 32'h40, {24'h0, REC_RESET});
    rd("gain reset", 32'h44, {24'h0, GAIN_RESET});
    rd("range reset", 32'h48, {24'h0, RANGE_RESET});
    $display("test reset values done");
  endtask : t_reset_values
  task automatic t_reserved_bits;
    wr(32'h40, 32'hFFFF_FFFF);
    wr(32'h44, 32'hFFFF_FFFF);
    wr(32'h48, 32'hFFFF_FFFF);
    wr(32'h3FC, 32'hFFFF_FFFF);
    rd("recovery field", 32'h40, 32'h70);
    rd("gain field", 32'h44, 32'h07);
    rd("range field", 32'h48, 32'h20);
    rd("unmapped", 32'h3FC, 32'h0);
    $display("test reserved bits done");
  endtask : t_reserved_bits
  // every recovery code, gain as its complement
  task automatic t_vis_sweep;
    for (int c = 0; c < 8; c++) begin
      conv(3'(c), ~3'(c), c[0], 1'b0);
    end
    $display("test visible sweep done");
  endtask : t_vis_sweep
  task automatic t_ir_early;
    conv(3'h3, 3'h5, 1'b1, 1'b1);
    $display("test infrared early revision done");
  endtask : t_ir_early
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_reserved_bits();
    t_vis_sweep();
    t_ir_early();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_vlac_top
`default_nettype wire
